//--- tb_timer16_mode_control.sv
// Self-checking bench of the 16-bit timer mode control
`timescale 1ns/1ps
`include "tmc_defines.svh"
module tb_timer16_mode_control
    import tmc_pkg::*;
;
    localparam logic [11:0] A_CTLA = {`TMC_IDX_CTRL_A, 2'b00};
    localparam logic [11:0] A_CTLB = {`TMC_IDX_CTRL_B, 2'b00};
    localparam logic [11:0] A_CMPA = {`TMC_IDX_CMP_A, 2'b00};
    localparam logic [11:0] A_CAPT = {`TMC_IDX_CAPT, 2'b00};
    localparam logic [11:0] A_STAT = {`TMC_IDX_INT_STAT, 2'b00};
    localparam logic [11:0] A_MASK = {`TMC_IDX_INT_MASK, 2'b00};
    localparam logic [11:0] A_PIN  = {`TMC_IDX_PIN_CTL, 2'b00};
    localparam int          P      = 11;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        captureInput = 1'b0, externalCountPin = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, irq;
    tmc_pin_t    compareOutA, compareOutB;
    int          miscompares = 0, checksDone = 0, lat0, lat;
    int          divs [4] = '{8, 64, 256, 1024};

    tmc_timer16_mode_control dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .captureInput(captureInput), .externalCountPin(externalCountPin),
        .compareOutA(compareOutA), .compareOutB(compareOutB), .irq(irq));

    always #25 ref_clk = ~ref_clk;

    // ------------------------------
    // Bus and measurement tasks
    // ------------------------------
    task automatic report_and_stop;
        if (miscompares == 0 && checksDone > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : check

    // Leading idle edge keeps each bus signal assigned once per time step
    task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                        input logic [31:0] expRd, input logic expErr);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= adr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            report_and_stop();
        end
        if (!wr) begin
            check(prdata, expRd);
            check({31'h0, pslverr}, {31'h0, expErr});
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [11:0] adr, input logic [31:0] d);
        xfer(1'b1, adr, d, 32'h0, 1'b0);
    endtask : wr

    task automatic irq_chk(input logic e);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, {31'h0, e});
    endtask : irq_chk

    // Windows span whole periods, so the high count does not depend on phase
    task automatic run_mode(input logic [7:0] a, input logic [7:0] b, input int win,
                            input int exp);
        int h;
        h = 0;
        wr(A_CTLA, {24'h0, a});
        wr(A_CTLB, {24'h0, b});
        repeat (win) @(posedge ref_clk);
        repeat (win) begin
            @(posedge ref_clk);
            if (compareOutA.out === 1'b1) h++;
        end
        check(32'(h), 32'(exp));
    endtask : run_mode

    // Returns 30 when no interrupt shows within the window
    task automatic cap_lat(input logic lvl, output int n);
        n = 0;
        captureInput <= lvl;
        do begin
            @(posedge ref_clk);
            n++;
        end while (irq !== 1'b1 && n < 30);
    endtask : cap_lat

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, A_CTLA, 32'h0, 32'h0, 1'b0);
        wr(A_CTLA, 32'hff);
        wr(A_CTLB, 32'hff);
        xfer(1'b0, A_CTLA, 32'h0, 32'hf3, 1'b0);
        xfer(1'b0, A_CTLB, 32'h0, 32'hdf, 1'b0);
        xfer(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, 12'h0bd, 32'h0, 32'h0, 1'b1);
        wr(A_PIN, 32'h5);
        run_mode(8'h00, 8'h09, 2 * P, 2 * P);
        wr(A_CMPA, 32'd10);
        run_mode(8'h50, 8'h09, 2 * P, P);
        run_mode(8'ha0, 8'h09, 2 * P, 0);
        run_mode(8'hf0, 8'h09, 2 * P, 2 * P);
        check({31'h0, compareOutB.out}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            run_mode(8'h40, 8'(10 + i), 2 * P * divs[i], P * divs[i]);
        end
        wr(A_MASK, 32'h8);
        wr(A_CTLB, 32'h49);
        cap_lat(1'b1, lat0);
        check(32'(lat0 < 30), 32'h1);
        wr(A_STAT, 32'h8);
        irq_chk(1'b0);
        cap_lat(1'b0, lat);
        check(32'(lat), 32'd30);
        wr(A_CTLB, 32'hc9);
        captureInput <= 1'b1;
        repeat (3) @(posedge ref_clk);
        captureInput <= 1'b0;
        repeat (12) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        cap_lat(1'b1, lat);
        check(32'(lat), 32'(lat0 + 4));
        wr(A_MASK, 32'h0);
        irq_chk(1'b0);
        wr(A_MASK, 32'h8);
        irq_chk(1'b1);
        wr(A_STAT, 32'h8);
        irq_chk(1'b0);
        wr(A_CTLB, 32'h09);
        cap_lat(1'b0, lat);
        check(32'(lat), 32'(lat0));
        wr(A_STAT, 32'h8);
        wr(A_CAPT, 32'd10);
        run_mode(8'h40, 8'h19, 2 * P, P);
        wr(A_CMPA, 32'd3);
        run_mode(8'h40, 8'h19, 2 * P, P);
        cap_lat(1'b1, lat);
        cap_lat(1'b0, lat);
        check(32'(lat), 32'd30);
        xfer(1'b0, A_CAPT, 32'h0, 32'd10, 1'b0);
        run_mode(8'h82, 8'h19, P, 4);
        run_mode(8'hc2, 8'h19, P, P - 4);
        wr(A_CMPA, 32'd10);
        run_mode(8'h82, 8'h19, P, P);
        wr(A_CMPA, 32'd3);
        run_mode(8'h82, 8'h11, 20, 6);
        run_mode(8'hc2, 8'h11, 20, 14);
        run_mode(8'h80, 8'h11, 20, 6);
        // Fixed 10-bit TOP dual slope; flags cleared first so overflow and both compare flags must reappear
        wr(A_STAT, 32'hf);
        run_mode(8'h83, 8'h01, 2 * `TMC_TOP_10BIT, 6);
        xfer(1'b0, A_STAT, 32'h0, 32'h7, 1'b0);
        run_mode(8'h55, 8'h09, P, P);
        report_and_stop();
    end
endmodule : tb_timer16_mode_control

//--- tmc_defines.svh
// Register indices, field positions, reset values and counts of the 16-bit timer mode control
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH
// Register indices: byte address is four times the index
`define TMC_IDX_CTRL_B      10'h02e
`define TMC_IDX_CTRL_A      10'h02f
`define TMC_IDX_CMP_A       10'h030
`define TMC_IDX_CMP_B       10'h031
`define TMC_IDX_CAPT        10'h032
`define TMC_IDX_CNT         10'h033
`define TMC_IDX_INT_STAT    10'h034
`define TMC_IDX_INT_MASK    10'h035
`define TMC_IDX_PIN_CTL     10'h036
// Control register A fields
`define TMC_A_CHA_MODE      7:6
`define TMC_A_CHB_MODE      5:4
`define TMC_A_WGM_LO        1:0
`define TMC_A_WMASK         8'hf3
// Control register B fields
`define TMC_B_FILT_EN       7
`define TMC_B_EDGE_SEL      6
`define TMC_B_WGM_HI        4:3
`define TMC_B_CLK_SEL       2:0
`define TMC_B_WMASK         8'hdf
`define TMC_CTRL_RESET      8'h00
// Interrupt status and mask bits
`define TMC_INT_OVF         0
`define TMC_INT_CMPA        1
`define TMC_INT_CMPB        2
`define TMC_INT_CAPT        3
`define TMC_INT_W           4
// Pin control bits
`define TMC_PIN_DIR_A       0
`define TMC_PIN_DIR_B       1
`define TMC_PIN_PORT_A      2
`define TMC_PIN_PORT_B      3
`define TMC_PIN_W           4
// Counter limits and fixed TOP values
`define TMC_BOTTOM          16'h0000
`define TMC_MAX             16'hffff
`define TMC_TOP_8BIT        16'h00ff
`define TMC_TOP_9BIT        16'h01ff
`define TMC_TOP_10BIT       16'h03ff
// Capture filter length in samples
`define TMC_FILT_SAMPLES    4
`endif

//--- tmc_pkg.sv
// Types shared by the 16-bit timer mode control
package tmc_pkg;
    typedef enum logic [1:0] {
        DIR_UP   = 2'h1,
        DIR_DOWN = 2'h2
    } tmc_dir_t;

    typedef enum logic [5:0] {
        KIND_NORMAL = 6'h01,
        KIND_CTC    = 6'h02,
        KIND_FAST   = 6'h04,
        KIND_PC     = 6'h08,
        KIND_PFC    = 6'h10,
        KIND_RSVD   = 6'h20
    } tmc_kind_t;

    typedef struct packed {
        logic out;
        logic oe;
    } tmc_pin_t;
endpackage : tmc_pkg

//--- tmc_timer16_mode_control.sv
// 16-bit timer/counter with waveform mode decode, compare outputs, capture filter and APB registers
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "tmc_defines.svh"

// How it works
// - Channel A mode nonzero routes output A to pin, except PWM code 01 without mode msb
// - Channel B mode nonzero routes output B to pin, except PWM code 01
// - Routed output driven only when direction selects output
// - Non-PWM codes: off, toggle, clear, set on match
// - Fast PWM: 10 clear-match/set-bottom, 11 inverse
// - PWM code 01: toggles A only if mode msb
// - Fast PWM: match at TOP ignored, bottom action kept
// - Dual-slope: 10 clears up, sets down; 11 inverse
// - Mode is two low plus two high control bits
// - Modes 0,4,12: immediate update, overflow at MAX
// - Fixed-TOP phase correct and fast PWM update/flag points
// - Modes 8-15 update and flag points; 13 reserved
// - Modes 8,10,12,14 use capture TOP; 4,9,11,15 compare A
// - Filter output changes after four equal samples
// - Filtered capture events arrive four cycles later
// - Edge select chooses edge; capture copies counter, flags
// - Clock source field picks stop, prescale or pin edge
// - Capture disabled while capture value is TOP
module tmc_timer16_mode_control
    import tmc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        captureInput,
    input  wire logic        externalCountPin,
    output tmc_pin_t         compareOutA,
    output tmc_pin_t         compareOutB,
    output logic             irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                    ctrlA;
        logic [7:0]                    ctrlB;
        logic [15:0]                   cmpBufA;
        logic [15:0]                   cmpBufB;
        logic [15:0]                   cmpActA;
        logic [15:0]                   cmpActB;
        logic [15:0]                   capt;
        logic [15:0]                   cnt;
        tmc_dir_t                      dir;
        logic [9:0]                    pre;
        logic                          extPrev;
        logic                          capRaw;
        logic [`TMC_FILT_SAMPLES-1:0]  filtSh;
        logic                          filtOut;
        logic                          capPrev;
        logic                          ocA;
        logic                          ocB;
        logic [`TMC_INT_W-1:0]         stat;
        logic [`TMC_INT_W-1:0]         mask;
        logic [`TMC_PIN_W-1:0]         pinCtl;
        logic [31:0]                   prdata;
    } tmc_state_t;

    tmc_state_t s_r;
    tmc_state_t s_nxt;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic tmc_kind_t modeKind(input logic [3:0] wgm);
        tmc_kind_t k;
        case (wgm)
            4'h0: k = KIND_NORMAL;
            4'h4, 4'hc: k = KIND_CTC;
            4'h1, 4'h2, 4'h3, 4'ha, 4'hb: k = KIND_PC;
            4'h5, 4'h6, 4'h7, 4'he, 4'hf: k = KIND_FAST;
            4'h8, 4'h9: k = KIND_PFC;
            default: k = KIND_RSVD;
        endcase
        return k;
    endfunction : modeKind

    function automatic logic [15:0] topValue(input logic [3:0] wgm,
                                             input logic [15:0] cmpA,
                                             input logic [15:0] capt);
        logic [15:0] t;
        case (wgm)
            4'h1, 4'h5: t = `TMC_TOP_8BIT;
            4'h2, 4'h6: t = `TMC_TOP_9BIT;
            4'h3, 4'h7: t = `TMC_TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: t = cmpA;
            4'h8, 4'ha, 4'hc, 4'he: t = capt;
            default: t = `TMC_MAX;
        endcase
        return t;
    endfunction : topValue

    // Code 01 in PWM modes only drives channel A, and only with the mode msb set
    function automatic logic chanRouted(input logic [1:0] code,
                                        input tmc_kind_t kind,
                                        input logic msb,
                                        input logic isA);
        logic pwm;
        pwm = (kind == KIND_FAST) || (kind == KIND_PC) || (kind == KIND_PFC);
        if (code == 2'h0) begin
            return 1'b0;
        end
        if (pwm && (code == 2'h1) && !(msb && isA)) begin
            return 1'b0;
        end
        return 1'b1;
    endfunction : chanRouted

    function automatic logic chanNext(input logic [1:0] code,
                                      input tmc_kind_t kind,
                                      input logic msb,
                                      input logic isA,
                                      input logic match,
                                      input logic up,
                                      input logic bottom,
                                      input logic cmpIsTop,
                                      input logic cur);
        logic v;
        v = cur;
        case (kind)
            KIND_NORMAL, KIND_CTC: begin
                if (match) begin
                    case (code)
                        2'h1: v = ~cur;
                        2'h2: v = 1'b0;
                        2'h3: v = 1'b1;
                        default: v = cur;
                    endcase
                end
            end
            KIND_FAST: begin
                if (code[1]) begin
                    if (match && !cmpIsTop) begin
                        v = code[0];
                    end
                    if (bottom) begin
                        v = ~code[0];
                    end
                end else if (code[0] && msb && isA && match) begin
                    v = ~cur;
                end
            end
            KIND_PC, KIND_PFC: begin
                if (code[1]) begin
                    if (match) begin
                        v = up ? code[0] : ~code[0];
                    end
                end else if (code[0] && msb && isA && match) begin
                    v = ~cur;
                end
            end
            default: v = cur;
        endcase
        return v;
    endfunction : chanNext

    function automatic logic addrHit(input logic [11:0] a);
        logic [9:0] idx;
        idx = a[11:2];
        if (a[1:0] != 2'h0) begin
            return 1'b0;
        end
        case (idx)
            `TMC_IDX_CTRL_B, `TMC_IDX_CTRL_A, `TMC_IDX_CMP_A, `TMC_IDX_CMP_B,
            `TMC_IDX_CAPT, `TMC_IDX_CNT, `TMC_IDX_INT_STAT, `TMC_IDX_INT_MASK,
            `TMC_IDX_PIN_CTL: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : addrHit

    // ------------------------------------------------------------
    // Combinational view
    // ------------------------------------------------------------
    logic [3:0]            wgm;
    tmc_kind_t             kind;
    logic [15:0]           top;
    logic                  tick;
    logic                  wrEn;
    logic [9:0]            wrIdx;
    logic                  atTop;
    logic                  atBottom;
    logic                  updNow;
    logic                  ovfEv;
    logic                  matchA;
    logic                  matchB;
    logic                  fastBottom;
    logic                  captSel;
    logic                  captEv;
    logic                  captOff;
    logic [`TMC_INT_W-1:0] setEv;
    logic [`TMC_INT_W-1:0] clrBits;
    logic                  routedA;
    logic                  routedB;

    always_comb begin
        s_nxt      = s_r;
        wgm        = {s_r.ctrlB[`TMC_B_WGM_HI], s_r.ctrlA[`TMC_A_WGM_LO]};
        kind       = modeKind(wgm);
        top        = topValue(wgm, s_r.cmpActA, s_r.capt);
        wrEn       = psel && penable && pwrite && addrHit(paddr);
        wrIdx      = paddr[11:2];
        tick       = 1'b0;
        atTop      = 1'b0;
        atBottom   = 1'b0;
        updNow     = 1'b0;
        ovfEv      = 1'b0;
        fastBottom = 1'b0;
        setEv      = '0;
        clrBits    = '0;

        // Prescaler and clock source
        s_nxt.pre     = s_r.pre + 10'h001;
        s_nxt.extPrev = externalCountPin;
        case (s_r.ctrlB[`TMC_B_CLK_SEL])
            3'h1: tick = 1'b1;
            3'h2: tick = &s_r.pre[2:0];
            3'h3: tick = &s_r.pre[5:0];
            3'h4: tick = &s_r.pre[7:0];
            3'h5: tick = &s_r.pre[9:0];
            3'h6: tick = s_r.extPrev && !externalCountPin;
            3'h7: tick = !s_r.extPrev && externalCountPin;
            default: tick = 1'b0;
        endcase
        // Reserved mode holds the counter rather than guess a sequence
        if (kind == KIND_RSVD) begin
            tick = 1'b0;
        end

        // Counting sequence
        atTop    = tick && (s_r.cnt == top);
        atBottom = tick && (s_r.cnt == `TMC_BOTTOM) && (s_r.dir == DIR_DOWN);
        matchA   = tick && (s_r.cnt == s_r.cmpActA);
        matchB   = tick && (s_r.cnt == s_r.cmpActB);
        if (tick) begin
            case (kind)
                KIND_PC, KIND_PFC: begin
                    if (s_r.dir == DIR_UP) begin
                        if (s_r.cnt == top) begin
                            s_nxt.dir = DIR_DOWN;
                            s_nxt.cnt = s_r.cnt - 16'h0001;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 16'h0001;
                        end
                    end else begin
                        if (s_r.cnt == `TMC_BOTTOM) begin
                            s_nxt.dir = DIR_UP;
                            s_nxt.cnt = s_r.cnt + 16'h0001;
                        end else begin
                            s_nxt.cnt = s_r.cnt - 16'h0001;
                        end
                    end
                end
                default: begin
                    s_nxt.dir = DIR_UP;
                    s_nxt.cnt = (s_r.cnt == top) ? `TMC_BOTTOM : s_r.cnt + 16'h0001;
                end
            endcase
        end

        // Compare update points and overflow points
        case (kind)
            KIND_NORMAL, KIND_CTC: begin
                updNow = 1'b1;
                ovfEv  = tick && (s_r.cnt == `TMC_MAX);
            end
            KIND_FAST: begin
                fastBottom = atTop;
                updNow     = atTop;
                ovfEv      = atTop;
            end
            KIND_PC: begin
                updNow = atTop && (s_r.dir == DIR_UP);
                ovfEv  = atBottom;
            end
            KIND_PFC: begin
                updNow = atBottom;
                ovfEv  = atBottom;
            end
            default: begin
                updNow = 1'b0;
                ovfEv  = 1'b0;
            end
        endcase

        // Waveform outputs use the compare values active at this tick
        s_nxt.ocA = chanNext(s_r.ctrlA[`TMC_A_CHA_MODE], kind, wgm[3], 1'b1, matchA,
                             s_r.dir == DIR_UP, fastBottom, s_r.cmpActA == top, s_r.ocA);
        s_nxt.ocB = chanNext(s_r.ctrlA[`TMC_A_CHB_MODE], kind, wgm[3], 1'b0, matchB,
                             s_r.dir == DIR_UP, fastBottom, s_r.cmpActB == top, s_r.ocB);

        // Capture input, optional noise filter
        s_nxt.capRaw = captureInput;
        s_nxt.filtSh = {s_r.filtSh[`TMC_FILT_SAMPLES-2:0], captureInput};
        if ((&s_r.filtSh) || !(|s_r.filtSh)) begin
            s_nxt.filtOut = s_r.filtSh[0];
        end
        captSel       = s_r.ctrlB[`TMC_B_FILT_EN] ? s_r.filtOut : s_r.capRaw;
        s_nxt.capPrev = captSel;
        captOff       = wgm[3] && !wgm[0];
        captEv        = !captOff && (s_r.ctrlB[`TMC_B_EDGE_SEL]
                        ? (!s_r.capPrev && captSel)
                        : (s_r.capPrev && !captSel));
        if (captEv) begin
            s_nxt.capt = s_r.cnt;
        end

        // Register writes
        if (wrEn) begin
            case (wrIdx)
                `TMC_IDX_CTRL_A: s_nxt.ctrlA = pwdata[7:0] & `TMC_A_WMASK;
                `TMC_IDX_CTRL_B: s_nxt.ctrlB = pwdata[7:0] & `TMC_B_WMASK;
                `TMC_IDX_CMP_A: s_nxt.cmpBufA = pwdata[15:0];
                `TMC_IDX_CMP_B: s_nxt.cmpBufB = pwdata[15:0];
                `TMC_IDX_CAPT: begin
                    if (!captEv) begin
                        s_nxt.capt = pwdata[15:0];
                    end
                end
                `TMC_IDX_INT_STAT: clrBits = pwdata[`TMC_INT_W-1:0];
                `TMC_IDX_INT_MASK: s_nxt.mask = pwdata[`TMC_INT_W-1:0];
                `TMC_IDX_PIN_CTL: s_nxt.pinCtl = pwdata[`TMC_PIN_W-1:0];
                default: ;
            endcase
        end
        if (updNow) begin
            s_nxt.cmpActA = s_nxt.cmpBufA;
            s_nxt.cmpActB = s_nxt.cmpBufB;
        end

        // Sticky events; a set in the clearing cycle survives
        setEv[`TMC_INT_OVF]  = ovfEv;
        setEv[`TMC_INT_CMPA] = matchA;
        setEv[`TMC_INT_CMPB] = matchB;
        setEv[`TMC_INT_CAPT] = captEv;
        s_nxt.stat = (s_r.stat & ~clrBits) | setEv;

        // Read data is captured in the setup phase
        if (psel && !penable) begin
            case (paddr[1:0] == 2'h0 ? paddr[11:2] : 10'h000)
                `TMC_IDX_CTRL_A: s_nxt.prdata = {24'h000000, s_r.ctrlA};
                `TMC_IDX_CTRL_B: s_nxt.prdata = {24'h000000, s_r.ctrlB};
                `TMC_IDX_CMP_A: s_nxt.prdata = {16'h0000, s_r.cmpBufA};
                `TMC_IDX_CMP_B: s_nxt.prdata = {16'h0000, s_r.cmpBufB};
                `TMC_IDX_CAPT: s_nxt.prdata = {16'h0000, s_r.capt};
                `TMC_IDX_CNT: s_nxt.prdata = {16'h0000, s_r.cnt};
                `TMC_IDX_INT_STAT: s_nxt.prdata = {28'h0000000, s_r.stat};
                `TMC_IDX_INT_MASK: s_nxt.prdata = {28'h0000000, s_r.mask};
                `TMC_IDX_PIN_CTL: s_nxt.prdata = {28'h0000000, s_r.pinCtl};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= '{ctrlA: `TMC_CTRL_RESET, ctrlB: `TMC_CTRL_RESET,
                     dir: DIR_UP, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        routedA = chanRouted(s_r.ctrlA[`TMC_A_CHA_MODE], modeKind(wgm), wgm[3], 1'b1);
        routedB = chanRouted(s_r.ctrlA[`TMC_A_CHB_MODE], modeKind(wgm), wgm[3], 1'b0);
        compareOutA.out = routedA ? s_r.ocA : s_r.pinCtl[`TMC_PIN_PORT_A];
        compareOutB.out = routedB ? s_r.ocB : s_r.pinCtl[`TMC_PIN_PORT_B];
        compareOutA.oe  = s_r.pinCtl[`TMC_PIN_DIR_A];
        compareOutB.oe  = s_r.pinCtl[`TMC_PIN_DIR_B];
    end

    assign prdata  = s_r.prdata;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrHit(paddr);
    assign irq     = |(s_r.stat & s_r.mask);

endmodule : tmc_timer16_mode_control

//--- tmc_timer16_mode_control_monitor.sv
// Port assertions of the 16-bit timer mode control
`timescale 1ns/1ps
`include "tmc_defines.svh"
module tmc_timer16_mode_control_monitor
    import tmc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        captureInput,
    input wire logic        externalCountPin,
    input wire tmc_pin_t    compareOutA,
    input wire tmc_pin_t    compareOutB,
    input wire logic        irq
);
    // ------------------------------
    // Control bits mirrored from bus writes
    // ------------------------------
    logic [7:0] ctlA_r, ctlB_r;
    logic [3:0] pin_r, mode;
    logic       pwm, wrEn, rdEn;
    assign wrEn = psel && penable && pwrite && pready;
    assign rdEn = psel && penable && !pwrite;
    assign mode = {ctlB_r[4:3], ctlA_r[1:0]};
    assign pwm  = !(mode inside {4'h0, 4'h4, 4'hc, 4'hd});
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctlA_r <= 8'h00;
            ctlB_r <= 8'h00;
            pin_r  <= 4'h0;
        end else if (wrEn) begin
            if (paddr == {`TMC_IDX_CTRL_A, 2'b00}) ctlA_r <= pwdata[7:0] & `TMC_A_WMASK;
            if (paddr == {`TMC_IDX_CTRL_B, 2'b00}) ctlB_r <= pwdata[7:0] & `TMC_B_WMASK;
            if (paddr == {`TMC_IDX_PIN_CTL, 2'b00}) pin_r <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ------------------------------
    // Checks
    // ------------------------------
    chk_enable_dir: assert property ({compareOutB.oe, compareOutA.oe} == pin_r[1:0])
        else $error("pin enable differs from direction");
    chk_port_a_off: assert property (ctlA_r[7:6] == 2'h0 |-> compareOutA.out == pin_r[2])
        else $error("pin A not on port data");
    chk_port_b_off: assert property (ctlA_r[5:4] == 2'h0 |-> compareOutB.out == pin_r[3])
        else $error("pin B not on port data");
    chk_pwm_a_unrouted: assert property (
        pwm && !mode[3] && ctlA_r[7:6] == 2'h1 |-> compareOutA.out == pin_r[2])
        else $error("pin A routed with code one");
    chk_pwm_b_unrouted: assert property (
        pwm && ctlA_r[5:4] == 2'h1 |-> compareOutB.out == pin_r[3])
        else $error("pin B routed with code one");
    chk_ctl_a_read: assert property (
        rdEn && paddr == {`TMC_IDX_CTRL_A, 2'b00} |-> prdata == {24'h000000, ctlA_r})
        else $error("control A read value wrong");
    chk_ctl_b_read: assert property (
        rdEn && paddr == {`TMC_IDX_CTRL_B, 2'b00} |-> prdata == {24'h000000, ctlB_r})
        else $error("control B read value wrong");
    chk_clear_no_rise: assert property (!pwm && ctlA_r[7:6] == 2'h2
        && ctlA_r == $past(ctlA_r, 2) && $stable(ctlA_r) |-> !$rose(compareOutA.out))
        else $error("clear code raised pin A");
    chk_set_no_fall: assert property (!pwm && ctlA_r[5:4] == 2'h3
        && ctlA_r == $past(ctlA_r, 2) && $stable(ctlA_r) |-> !$fell(compareOutB.out))
        else $error("set code lowered pin B");
endmodule : tmc_timer16_mode_control_monitor

bind tmc_timer16_mode_control tmc_timer16_mode_control_monitor u_mon (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .captureInput(captureInput), .externalCountPin(externalCountPin),
    .compareOutA(compareOutA), .compareOutB(compareOutB), .irq(irq));
